// ===== src/slcr_map.svh
// Register indexes, field positions, reset values and codes of the link registers.
`ifndef SLCR_MAP_SVH
`define SLCR_MAP_SVH

// ----------------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------------
`define SLCR_IDX_EN 10'h200
`define SLCR_IDX_MODE 10'h201
`define SLCR_IDX_KM1 10'h202
`define SLCR_IDX_SYNC 10'h203
`define SLCR_IDX_CTRL 10'h204
`define SLCR_IDX_STAT 10'h208

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SLCR_RST_EN 1'b1
`define SLCR_RST_MODE 6'h00
`define SLCR_RST_KM1 8'h1f
`define SLCR_RST_SYNC 1'b1
`define SLCR_RST_CTRL 5'h03
// Alt lanes, format and scrambler bits of the control reset, as packed.
`define SLCR_RST_CFG_BITS 3'b011

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SLCR_CTRL_SCR 0
`define SLCR_CTRL_FMT 1
`define SLCR_CTRL_SEL_LSB 2
`define SLCR_CTRL_SEL_MSB 3
`define SLCR_CTRL_ALT 4
`define SLCR_STAT_CLR_BIT 1

// ----------------------------------------------------------------------
// Mode decoding and bus answers
// ----------------------------------------------------------------------
`define SLCR_MODE_64B_FIRST 6'h1e
`define SLCR_K64_BASE 8'h00
`define SLCR_RESP_OKAY 2'h0
`define SLCR_RESP_SLVERR 2'h2

`endif

// ===== src/slcr_mode_decode.sv
// Output mode decoder: link layer kind and effective multiframe length.
`timescale 1ns/1ps
`include "slcr_map.svh"

module slcr_mode_decode (
	// Selected output mode
	input wire logic [5:0] mode,
	// Decoded link layer
	output logic is_64b66b,
	output logic [11:0] k_eff
);

	logic [2:0] e_val;
	logic [1:0] f_log2;

	// ------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------
	// F is a power of two here, so 256*E/F is an exact shift.
	always_comb begin
		is_64b66b = (mode >= `SLCR_MODE_64B_FIRST);
		e_val = 3'h1 + {1'b0, mode[3:2]};
		f_log2 = mode[1:0];
		k_eff = {1'b0, e_val, `SLCR_K64_BASE} >> f_log2;
	end

endmodule

// ===== src/slcr_pkg.sv
// Types shared by the serial link control register block.
package slcr_pkg;

	// Sync source selection codes.
	typedef enum logic [1:0] {
		SLCR_SYNC_SE = 2'b00,
		SLCR_SYNC_TS = 2'b01,
		SLCR_SYNC_NONE = 2'b10,
		SLCR_SYNC_RSVD = 2'b11
	} slcr_sync_sel_type;

	// Configuration in use by the link.
	typedef struct packed {
		logic [5:0] mode;
		logic [7:0] km1;
		logic alt_lanes;
		logic sformat;
		logic scrambler;
	} slcr_cfg_type;

	// Power, reset and clock controls of the link block.
	typedef struct packed {
		logic rst_n;
		logic serdes_pd;
		logic clk_en;
		logic mf_cnt_rst;
	} slcr_link_ctl_type;

endpackage

// ===== src/slcr_sync_select.sv
// Sync request combiner: pin chosen by the source field plus software bit.
`timescale 1ns/1ps

module slcr_sync_select (
	// Source selection and software request
	input wire slcr_pkg::slcr_sync_sel_type sel,
	input wire logic soft_n,
	// Active low sync pins
	input wire logic se_pin_n,
	input wire logic ts_pin_n,
	// Combined request, active high
	output logic req
);

	logic pin_req;

	// ------------------------------------------------------------------
	// Combine
	// ------------------------------------------------------------------
	// The software bit always adds in; a stuck pin is silenced by
	// choosing the other pin, the no-pin or the reserved source.
	always_comb begin
		pin_req = 1'b0;
		unique case (sel)
			slcr_pkg::SLCR_SYNC_SE: pin_req = !se_pin_n;
			slcr_pkg::SLCR_SYNC_TS: pin_req = !ts_pin_n;
			slcr_pkg::SLCR_SYNC_NONE: pin_req = 1'b0;
			slcr_pkg::SLCR_SYNC_RSVD: pin_req = 1'b0;
		endcase
		req = !soft_n || pin_req;
	end

endmodule

// ===== src/slcr_top.sv
// Serial link control registers behind an AXI4-Lite slave.
`timescale 1ns/1ps
`include "slcr_map.svh"

module slcr_top (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Active low sync pins
	input wire logic single_ended_sync_pin_n,
	input wire logic timestamp_pin_pair_n,
	// Link block controls
	output slcr_pkg::slcr_link_ctl_type link_ctl,
	output slcr_pkg::slcr_cfg_type link_cfg,
	output logic [11:0] effective_k,
	output logic link_is_64b66b,
	output logic sync_request
);

	// Decode of the mapped register indexes.
	function automatic logic is_mapped(input logic [9:0] idx);
		is_mapped = (idx >= `SLCR_IDX_EN && idx <= `SLCR_IDX_CTRL) ||
			idx == `SLCR_IDX_STAT;
	endfunction
	// ------------------------------------------------------------------
	// Bus slave state
	// ------------------------------------------------------------------
	logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
	logic w_strb_reg, w_strb_next, awready_reg, awready_next;
	logic wready_reg, wready_next, bvalid_reg, bvalid_next;
	logic arready_reg, arready_next, rvalid_reg, rvalid_next, do_write;
	logic [9:0] aw_idx_reg, aw_idx_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [7:0] w_data_reg, w_data_next, rdata_reg, rdata_next, rd_word;
	// Register state.
	logic link_en_reg, link_en_next, soft_n_reg, soft_n_next;
	logic viol_reg, viol_next;
	logic [5:0] mode_reg, mode_next;
	logic [7:0] km1_reg, km1_next;
	logic [4:0] ctrl_reg, ctrl_next;
	// Link side state.
	slcr_pkg::slcr_cfg_type cfg_reg, cfg_next, shadow_cfg;
	slcr_pkg::slcr_link_ctl_type ctl_reg, ctl_next;
	logic [11:0] eff_k_reg, eff_k_next, dec_k;
	logic is64_reg, is64_next, sync_req_reg, sync_req_next;
	logic dec_is64, sync_req_comb;
	logic [5:0] mode_wr;

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = {24'h000000, rdata_reg};
	assign link_ctl = ctl_reg;
	assign link_cfg = cfg_reg;
	assign effective_k = eff_k_reg;
	assign link_is_64b66b = is64_reg;
	assign sync_request = sync_req_reg;
	assign mode_wr = w_data_reg[5:0];

	// ------------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------------
	// Address and data are held separately so either may come first;
	// the write fires only once both are held and no response waits.
	always_comb begin
		do_write = aw_full_reg && w_full_reg && !bvalid_reg;
		aw_full_next = aw_full_reg;
		aw_idx_next = aw_idx_reg;
		w_full_next = w_full_reg;
		w_data_next = w_data_reg;
		w_strb_next = w_strb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		arready_next = arready_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		if (s_axi_awvalid && awready_reg) begin
			aw_full_next = 1'b1;
			aw_idx_next = s_axi_awaddr[11:2];
		end
		if (s_axi_wvalid && wready_reg) begin
			w_full_next = 1'b1;
			w_data_next = s_axi_wdata[7:0];
			w_strb_next = s_axi_wstrb[0];
		end
		if (do_write) begin
			aw_full_next = 1'b0;
			w_full_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = is_mapped(aw_idx_reg) ? `SLCR_RESP_OKAY :
				`SLCR_RESP_SLVERR;
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		awready_next = !aw_full_next && !bvalid_next;
		wready_next = !w_full_next && !bvalid_next;
		// Read mux; reserved and unmapped bits read as zero.
		case (s_axi_araddr[11:2])
			`SLCR_IDX_EN: rd_word = {7'h00, link_en_reg};
			`SLCR_IDX_MODE: rd_word = {2'h0, mode_reg};
			`SLCR_IDX_KM1: rd_word = km1_reg;
			`SLCR_IDX_SYNC: rd_word = {7'h00, soft_n_reg};
			`SLCR_IDX_CTRL: rd_word = {3'h0, ctrl_reg};
			`SLCR_IDX_STAT: rd_word = {4'h0, sync_req_reg, is64_reg,
				viol_reg, link_en_reg};
			default: rd_word = 8'h00;
		endcase
		if (s_axi_arvalid && arready_reg) begin
			arready_next = 1'b0;
			rvalid_next = 1'b1;
			rdata_next = rd_word;
			rresp_next = is_mapped(s_axi_araddr[11:2]) ?
				`SLCR_RESP_OKAY : `SLCR_RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
			arready_next = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			aw_idx_reg <= 10'h000;
			w_full_reg <= 1'b0;
			w_data_reg <= 8'h00;
			w_strb_reg <= 1'b0;
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			bvalid_reg <= 1'b0;
			bresp_reg <= `SLCR_RESP_OKAY;
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rresp_reg <= `SLCR_RESP_OKAY;
			rdata_reg <= 8'h00;
		end else begin
			aw_full_reg <= aw_full_next;
			aw_idx_reg <= aw_idx_next;
			w_full_reg <= w_full_next;
			w_data_reg <= w_data_next;
			w_strb_reg <= w_strb_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
		end
	end

	// ------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------
	// Only byte lane 0 carries data. A config write while enabled sets
	// the violation flag, and that set beats a same-cycle clear.
	always_comb begin
		link_en_next = link_en_reg;
		mode_next = mode_reg;
		km1_next = km1_reg;
		soft_n_next = soft_n_reg;
		ctrl_next = ctrl_reg;
		if (do_write && w_strb_reg) begin
			case (aw_idx_reg)
				`SLCR_IDX_EN: link_en_next = w_data_reg[0];
				`SLCR_IDX_MODE: mode_next = mode_wr;
				`SLCR_IDX_KM1: km1_next = w_data_reg;
				`SLCR_IDX_SYNC: soft_n_next = w_data_reg[0];
				`SLCR_IDX_CTRL: ctrl_next = w_data_reg[4:0];
				default: ;
			endcase
		end
		viol_next = viol_reg;
		if (do_write && w_strb_reg && aw_idx_reg == `SLCR_IDX_STAT &&
			w_data_reg[`SLCR_STAT_CLR_BIT]) begin
			viol_next = 1'b0;
		end
		if (do_write && link_en_reg && (aw_idx_reg == `SLCR_IDX_MODE ||
			aw_idx_reg == `SLCR_IDX_KM1 ||
			aw_idx_reg == `SLCR_IDX_CTRL)) begin
			viol_next = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link_en_reg <= `SLCR_RST_EN;
			mode_reg <= `SLCR_RST_MODE;
			km1_reg <= `SLCR_RST_KM1;
			soft_n_reg <= `SLCR_RST_SYNC;
			ctrl_reg <= `SLCR_RST_CTRL;
			viol_reg <= 1'b0;
		end else begin
			link_en_reg <= link_en_next;
			mode_reg <= mode_next;
			km1_reg <= km1_next;
			soft_n_reg <= soft_n_next;
			ctrl_reg <= ctrl_next;
			viol_reg <= viol_next;
		end
	end

	// ------------------------------------------------------------------
	// Link side
	// ------------------------------------------------------------------
	slcr_mode_decode u_mode_decode (
		.mode(cfg_reg.mode),
		.is_64b66b(dec_is64),
		.k_eff(dec_k)
	);
	// Sync source follows the live field so a stuck pin can be escaped.
	slcr_sync_select u_sync_select (
		.sel(slcr_pkg::slcr_sync_sel_type'(
			ctrl_reg[`SLCR_CTRL_SEL_MSB:`SLCR_CTRL_SEL_LSB])),
		.soft_n(soft_n_reg),
		.se_pin_n(single_ended_sync_pin_n),
		.ts_pin_n(timestamp_pin_pair_n),
		.req(sync_req_comb)
	);

	// The in-use copy tracks the registers only while disabled, so it
	// freezes at the edge where the enable rises.
	always_comb begin
		shadow_cfg.mode = mode_reg;
		shadow_cfg.km1 = km1_reg;
		shadow_cfg.alt_lanes = ctrl_reg[`SLCR_CTRL_ALT];
		shadow_cfg.sformat = ctrl_reg[`SLCR_CTRL_FMT];
		shadow_cfg.scrambler = ctrl_reg[`SLCR_CTRL_SCR];
		cfg_next = link_en_reg ? cfg_reg : shadow_cfg;
		ctl_next.rst_n = link_en_reg;
		ctl_next.serdes_pd = !link_en_reg;
		ctl_next.clk_en = link_en_reg;
		ctl_next.mf_cnt_rst = !link_en_reg;
		is64_next = dec_is64;
		eff_k_next = dec_is64 ? dec_k :
			{4'h0, cfg_reg.km1} + 12'h001;
		sync_req_next = sync_req_comb;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_reg <= {`SLCR_RST_MODE, `SLCR_RST_KM1, `SLCR_RST_CFG_BITS};
			ctl_reg <= 4'b1010;
			eff_k_reg <= 12'h020;
			is64_reg <= 1'b0;
			sync_req_reg <= 1'b0;
		end else begin
			cfg_reg <= cfg_next;
			ctl_reg <= ctl_next;
			eff_k_reg <= eff_k_next;
			is64_reg <= is64_next;
			sync_req_reg <= sync_req_next;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	a_enable_reset_one: assert property (@(posedge aclk) disable iff
		(!aresetn) !$past(aresetn) |-> link_en_reg && ctl_reg.rst_n)
		else $error("Link enable not set after reset.");
	a_disable_power_off: assert property (@(posedge aclk) disable iff
		(!aresetn) !link_en_reg |=> ctl_reg == 4'b0101)
		else $error("Disabled link not held off.");
	a_counter_held: assert property (@(posedge aclk) disable iff
		(!aresetn) $fell(link_en_reg) |-> ##1 ctl_reg.mf_cnt_rst [*2])
		else $error("Multiframe counter not held in reset.");
	a_mode_write: assert property (@(posedge aclk) disable iff
		(!aresetn) do_write && w_strb_reg && aw_idx_reg == `SLCR_IDX_MODE
		|=> mode_reg == $past(mode_wr))
		else $error("Mode field not written.");
	a_km1_reset: assert property (@(posedge aclk) disable iff
		(!aresetn) !$past(aresetn) |-> km1_reg == 8'h1f)
		else $error("Multiframe length reset wrong.");
	a_k_effective: assert property (@(posedge aclk) disable iff
		(!aresetn) !dec_is64 |=> eff_k_reg == $past(cfg_reg.km1) + 12'h001)
		else $error("Effective K does not follow length.");
	a_soft_sync: assert property (@(posedge aclk) disable iff
		(!aresetn) !soft_n_reg |=> sync_req_reg)
		else $error("Software sync not requested.");
	a_no_pin_quiet: assert property (@(posedge aclk) disable iff
		(!aresetn) soft_n_reg && ctrl_reg[3:2] == 2'h2 |=> !sync_req_reg)
		else $error("Pin sync leaks with no-pin source.");
	a_pin_select: assert property (@(posedge aclk) disable iff
		(!aresetn) soft_n_reg && ctrl_reg[3:2] == 2'h0
		|=> sync_req_reg == !$past(single_ended_sync_pin_n))
		else $error("Single pin source not followed.");
	a_cfg_frozen: assert property (@(posedge aclk) disable iff
		(!aresetn) link_en_reg && $past(link_en_reg) |=> $stable(cfg_reg))
		else $error("Config changed while link enabled.");

endmodule

// ===== tb/slcr_top_tb.sv
// Self-checking bench for the serial link control register block.
`timescale 1ns/1ps

module slcr_top_tb;

	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic [11:0] s_axi_araddr = 12'h000;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic single_ended_sync_pin_n = 1'b1;
	logic timestamp_pin_pair_n = 1'b1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	slcr_pkg::slcr_link_ctl_type link_ctl;
	slcr_pkg::slcr_cfg_type link_cfg;
	logic [11:0] effective_k;
	logic link_is_64b66b, sync_request;
	int n_fail = 0;
	int compares = 0;
	logic [31:0] rd;
	logic [1:0] resp;

	// Register table rows: write flag, strobe, address, data, readback, resp.
	typedef struct packed {
		logic wr; logic st; logic [11:0] a;
		logic [7:0] d; logic [7:0] q; logic [1:0] r;
	} slcr_row_type;
	slcr_row_type rows [13] = '{
		'{1'b0, 1'b0, 12'h800, 8'h00, 8'h01, 2'h0},
		'{1'b0, 1'b0, 12'h804, 8'h00, 8'h00, 2'h0},
		'{1'b0, 1'b0, 12'h808, 8'h00, 8'h1f, 2'h0},
		'{1'b0, 1'b0, 12'h80c, 8'h00, 8'h01, 2'h0},
		'{1'b0, 1'b0, 12'h810, 8'h00, 8'h03, 2'h0},
		'{1'b1, 1'b1, 12'h800, 8'h00, 8'h00, 2'h0},
		'{1'b1, 1'b1, 12'h804, 8'h15, 8'h15, 2'h0},
		'{1'b1, 1'b1, 12'h808, 8'h07, 8'h07, 2'h0},
		'{1'b1, 1'b0, 12'h808, 8'h55, 8'h07, 2'h0},
		'{1'b1, 1'b1, 12'h80c, 8'h00, 8'h00, 2'h0},
		'{1'b1, 1'b1, 12'h80c, 8'h01, 8'h01, 2'h0},
		'{1'b1, 1'b1, 12'h810, 8'h08, 8'h08, 2'h0},
		'{1'b1, 1'b1, 12'h9f0, 8'h5a, 8'h00, 2'h2}};
	// Sync cases: source, single pin, pin pair, software bit, request.
	logic [5:0] syn [8] = '{6'b000111, 6'b001010, 6'b011011, 6'b010110,
		6'b100010, 6'b101101, 6'b011101, 6'b110010};

	slcr_top slcr_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.single_ended_sync_pin_n, .timestamp_pin_pair_n, .link_ctl,
		.link_cfg, .effective_k, .link_is_64b66b, .sync_request);

	// ------------------------------------------------------------
	// Clock, compare and bus tasks
	// ------------------------------------------------------------
	initial begin
		forever #20 aclk = ~aclk;
	end

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Address and data go out together; each is dropped once taken.
	task automatic axi_wr(input logic [11:0] a, input logic [7:0] d,
		input logic st, output logic [1:0] r);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {24'h000000, d};
		s_axi_wstrb <= {3'h0, st};
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && s_axi_awready === 1'b1) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1) @(posedge aclk);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic wrap_up;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Whole run needs a few hundred cycles; this is far beyond it.
	initial begin
		#(40 * 20000);
		n_fail++;
		$display("[ERR] watchdog expected finish seen hang");
		wrap_up();
	end

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				axi_wr(rows[i].a, rows[i].d, rows[i].st, resp);
				chk("bresp", resp, rows[i].r);
			end
			axi_rd(rows[i].a, rd, resp);
			chk("rdata", rd, rows[i].q);
			chk("rresp", resp, rows[i].r);
		end
		$display("register table rows done");
		// Disabled link: held in reset, config follows the registers.
		repeat (3) @(posedge aclk);
		chk("link_ctl off", link_ctl, 4'h5);
		chk("k from km1", effective_k, 12'd8);
		chk("is64", link_is_64b66b, 1'b0);
		axi_wr(12'h800, 8'h01, 1'b1, resp);
		repeat (2) @(posedge aclk);
		chk("link_ctl on", link_ctl, 4'ha);
		axi_wr(12'h808, 8'h0f, 1'b1, resp);
		repeat (3) @(posedge aclk);
		chk("km1 frozen", link_cfg.km1, 8'h07);
		chk("k frozen", effective_k, 12'd8);
		// The late length write must show in the sticky status bit.
		axi_rd(12'h820, rd, resp);
		chk("status viol", rd, 32'h00000003);
		axi_wr(12'h820, 8'h02, 1'b1, resp);
		axi_rd(12'h820, rd, resp);
		chk("status clr", rd, 32'h00000001);
		axi_wr(12'h800, 8'h00, 1'b1, resp);
		axi_wr(12'h800, 8'h01, 1'b1, resp);
		repeat (3) @(posedge aclk);
		chk("k applied", effective_k, 12'd16);
		$display("enable sequencing done");
		// Mode 0x1f decodes as E 4, F 8, so length is ignored.
		axi_wr(12'h800, 8'h00, 1'b1, resp);
		axi_wr(12'h804, 8'h1f, 1'b1, resp);
		repeat (3) @(posedge aclk);
		chk("is64", link_is_64b66b, 1'b1);
		chk("k 64b66b", effective_k, 12'd128);
		$display("64b66b mode done");
		foreach (syn[i]) begin
			axi_wr(12'h810, {4'h0, syn[i][5:4], 2'b00}, 1'b1, resp);
			axi_wr(12'h80c, {7'h00, syn[i][1]}, 1'b1, resp);
			@(posedge aclk);
			single_ended_sync_pin_n <= syn[i][3];
			timestamp_pin_pair_n <= syn[i][2];
			repeat (3) @(posedge aclk);
			chk("sync_request", sync_request, syn[i][0]);
		end
		$display("sync source done");
		// Reset again in mid-run with the link reconfigured.
		@(posedge aclk);
		single_ended_sync_pin_n <= 1'b1;
		timestamp_pin_pair_n <= 1'b1;
		aresetn <= 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("link_ctl rst", link_ctl, 4'ha);
		chk("cfg rst", link_cfg, {6'h00, 8'h1f, 3'b011});
		chk("k rst", effective_k, 12'd32);
		chk("sync rst", sync_request, 1'b0);
		axi_rd(12'h808, rd, resp);
		chk("km1 rst", rd, 32'h0000001f);
		$display("second reset done");
		wrap_up();
	end

endmodule
